// >>> bench/tb_top.sv
// Testbench with reference model for the datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic MCLK, CMD_VALID, CMD_READY, CMD_RUNG_IN, RES_VALID, RES_RUNG_OUT, HOST_READY;
  logic HOST_RVALID;
  logic ARST_N = 1'b0;
  logic RES_READY = 1'b0;
  logic HOST_WE = 1'b0;
  logic HOST_RE = 1'b0;
  logic [2:0] CMD_OP;
  logic [11:0] CMD_A, CMD_B, CMD_C;
  logic [11:0] HOST_ADDR = 12'h000;
  logic [10:0] CMD_N;
  logic [15:0] HOST_WDATA = 16'h0000;
  logic [15:0] HOST_RDATA;
  logic [15:0] m [4096];
  logic [15:0] pre [4] = '{16'h7FFF, 16'h0001, 16'h8000, 16'hFFFF};
  logic [31:0] r = 32'h617C;
  bit eq [$];
  int rr = 1;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Directed commands: op, input, A, B, C, N
  int tv [19][6] = '{'{0,1,3,9,0,1}, '{1,1,5,10,0,4}, '{1,1,6,50,0,1}, '{2,1,10,12,0,5},
    '{3,1,30,27,0,5}, '{2,1,20,18,0,6}, '{3,1,33,35,0,4}, '{4,1,40,41,44,1}, '{4,1,42,43,45,1},
    '{5,1,40,43,46,1}, '{5,1,42,41,47,1}, '{4,1,41,43,48,1}, '{5,1,41,43,49,1},
    '{2,1,0,60,0,0}, '{3,1,0,60,0,1025}, '{6,1,0,1,2,1}, '{7,1,0,1,2,1}, '{2,0,0,60,0,3},
    '{1,1,5,3000,0,1024}};
  tmsa_core #(.AW(12)) i_tmsa_core (.*);
  tmsa_seq_model i_tmsa_seq_model (.clk(MCLK), .ready(CMD_READY), .valid(CMD_VALID),
    .op(CMD_OP), .rung(CMD_RUNG_IN), .a(CMD_A), .b(CMD_B), .c(CMD_C), .n(CMD_N));
  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reference model; source is copied first, so overlap cannot corrupt it
  task automatic run(input int o, g, a, b, c, n);
    logic [15:0] t [$];
    int s;
    bit on;
    bit sat;
    on = g && o < 6 && n > 0 && n < 1025;
    sat = 0;
    for (int i = 0; i < n && on; i++) t.push_back(m[a + i]);
    if (on && o == 0) begin
      m[a] = m[b];
      m[b] = t[0];
    end
    if (on && o inside {[1:3]})
      for (int i = 0; i < n; i++) m[b + i] = o == 1 ? t[0] : o == 3 ? ~t[i] : t[i];
    if (on && o > 3) begin
      s = o == 4 ? $signed(m[a]) + $signed(m[b]) : $signed(m[a]) - $signed(m[b]);
      sat = s > 32767 || s < -32768;
      m[c] = s > 32767 ? 16'h7FFF : s < -32768 ? 16'h8000 : s[15:0];
    end
    eq.push_back(on && (o < 4 || sat));
    r = lfsr(r);
    i_tmsa_seq_model.issue(o[2:0], g[0], a[11:0], b[11:0], c[11:0], n[10:0], r[1:0]);
  endtask
  // Host write or read through the register file port
  task automatic host(input bit rd, input int a, input logic [15:0] d);
    @(posedge MCLK);
    #1;
    {HOST_WE, HOST_RE, HOST_ADDR, HOST_WDATA} = {!rd, rd, a[11:0], d};
    do @(negedge MCLK); while (HOST_READY !== 1'b1);
    @(posedge MCLK);
    #1;
    {HOST_WE, HOST_RE} = 2'h0;
    if (rd) begin
      @(negedge MCLK);
      chk({15'h0, HOST_RVALID}, 16'h1, "read valid");
      // Read word lands one cycle after the valid pulse, behind the file's own register
      @(negedge MCLK);
      chk(HOST_RDATA, d, "read data");
    end else
      m[a] = d;
  endtask
  task automatic drain;
    for (int k = 0; k < 3000 && eq.size() > 0; k++) @(posedge MCLK);
    @(posedge MCLK);
  endtask
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  // Receiver: stalled, ready or random; also the run limit
  always @(posedge MCLK) begin
    #1;
    if (rr == 2) r = lfsr(r);
    RES_READY = rr == 2 ? r[2] : rr[0];
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("ERROR %0t run too long", $time);
      conclude();
    end
  end
  // Each delivered result against the oldest expected one
  always @(negedge MCLK) if (ARST_N && RES_VALID === 1'b1 && RES_READY) begin
    chk({15'h0, RES_RUNG_OUT}, {15'h0, eq.size() ? eq.pop_front() : 1'bx}, "rung");
  end
  initial begin
    repeat (4) @(posedge MCLK);
    #1;
    ARST_N = 1'b1;
    for (int i = 0; i < 68; i++) begin
      r = lfsr(r);
      host(0, i < 64 ? i : i - 24, i < 64 ? r[15:0] : pre[i - 64]);
    end
    $display("test init done");
    foreach (tv[i]) begin
      run(tv[i][0], tv[i][1], tv[i][2], tv[i][3], tv[i][4], tv[i][5]);
      drain();
    end
    $display("test directed done");
    rr = 0;
    repeat (3) run(6, 1, 0, 0, 0, 1);
    repeat (10) @(posedge MCLK);
    @(negedge MCLK);
    chk({15'h0, CMD_READY}, 16'h0, "ready while buffer full");
    rr = 1;
    drain();
    $display("test buffer done");
    rr = 2;
    repeat (16) begin
      r = lfsr(r);
      run(r[2:0], r[5] | r[6], r[13:8] % 48, r[21:16] % 48, r[27:22], r[30:28] + 1);
    end
    rr = 1;
    drain();
    $display("test random done");
    foreach (m[i]) if (i < 64 || i == 3000 || i == 4023) host(1, i, m[i]);
    $display("test readback done");
    // A result that never came would otherwise slip through
    chk(16'(eq.size()), 16'h0, "results outstanding");
    conclude();
  end
endmodule // tb_top
`default_nettype wire

// >>> bench/tmsa_core_props.sv
// Checker on the datapath top module ports
`timescale 1ns/1ps
`default_nettype none
module tmsa_core_props #(
  parameter int AW = 12
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire logic [2:0] CMD_OP,
  input wire logic CMD_RUNG_IN,
  input wire logic [10:0] CMD_N,
  input wire logic RES_VALID,
  input wire logic RES_READY,
  input wire logic RES_RUNG_OUT,
  input wire logic HOST_RE,
  input wire logic HOST_READY,
  input wire logic HOST_RVALID
);
  // ====================
  // Clock, reset and shared steps
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  // Take with empty buffer, so latency counts from here
  sequence s_take;
    CMD_VALID && CMD_READY && !RES_VALID;
  endsequence
  sequence s_quiet;
    !RES_VALID [*4];
  endsequence
  // ====================
  // Handshakes and latencies
  a_busy_after_take: assert property (
    CMD_VALID && CMD_READY |=> !CMD_READY) else $error("ready held after take");
  a_result_holds: assert property (
    RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_RUNG_OUT)) else $error("result lost");
  a_off_no_rung: assert property (
    s_take ##0 (!CMD_RUNG_IN || CMD_OP > 3'h5) |-> ##1 !RES_VALID ##1 RES_VALID && !RES_RUNG_OUT)
    else $error("idle command result wrong");
  a_swap_rung_on: assert property (
    s_take ##0 (CMD_RUNG_IN && CMD_OP == 3'h0) |-> ##1 s_quiet ##1 !RES_VALID ##1 RES_RUNG_OUT)
    else $error("swap result wrong");
  a_arith_timing: assert property (
    s_take ##0 (CMD_RUNG_IN && CMD_OP inside {3'h4, 3'h5}) |-> ##1 s_quiet ##1 RES_VALID)
    else $error("arith result late");
  a_fill_one: assert property (
    s_take ##0 (CMD_RUNG_IN && CMD_OP == 3'h1 && CMD_N == 11'h001)
    |-> ##1 s_quiet ##1 RES_RUNG_OUT)
    else $error("fill result wrong");
  a_read_answer: assert property (
    HOST_RE && HOST_READY |=> HOST_RVALID) else $error("read not answered");
  a_read_refused: assert property (
    !(HOST_RE && HOST_READY) |=> !HOST_RVALID) else $error("stray read answer");
endmodule // tmsa_core_props
bind tmsa_core tmsa_core_props #(.AW(AW)) i_tmsa_core_props (.*);
`default_nettype wire

// >>> bench/tmsa_seq_model.sv
// Sequencer model offering commands to the datapath
`timescale 1ns/1ps
`default_nettype none
module tmsa_seq_model (
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output logic [2:0] op,
  output logic rung,
  output logic [11:0] a,
  output logic [11:0] b,
  output logic [11:0] c,
  output logic [10:0] n
);
  // Idle at time zero
  initial begin
    {valid, op, rung, a, b, c, n} = '0;
  end
  // Hold the command until taken; garble op and the A, B, C fields after, while rung and N stay as issued
  task automatic issue(input logic [2:0] o, input logic g, input logic [11:0] x, y, z,
      input logic [10:0] k, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    valid = 1'b1;
    {op, rung, a, b, c, n} = {o, g, x, y, z, k};
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    #1;
    valid = 1'b0;
    {op, a, b, c} = ~{o, x, y, z};
  endtask
endmodule // tmsa_seq_model
`default_nettype wire

// >>> rtl/tmsa_consts.svh
// Constants for the table move and saturating add/sub datapath
`ifndef TMSA_CONSTS_SVH
`define TMSA_CONSTS_SVH
// ==================================================
// Word and table limits
`define TMSA_WORD_W 16
`define TMSA_N_W 11
`define TMSA_N_MIN 11'h001
`define TMSA_N_MAX 11'h400
// ==================================================
// Saturation limits, two's complement
`define TMSA_SAT_MAX 16'h7FFF
`define TMSA_SAT_MIN 16'h8000
// ==================================================
// Default register file depth as address width
`define TMSA_ADDR_W 12
`endif

// >>> rtl/tmsa_core.sv
// Table move and saturating add/sub datapath, top module
`timescale 1ns/1ps
`default_nettype none
`include "tmsa_consts.svh"
module tmsa_core
  import tmsa_pkg::*;
#(
  parameter int AW = `TMSA_ADDR_W
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [2:0] CMD_OP,
  input wire logic CMD_RUNG_IN,
  input wire logic [AW-1:0] CMD_A,
  input wire logic [AW-1:0] CMD_B,
  input wire logic [AW-1:0] CMD_C,
  input wire logic [`TMSA_N_W-1:0] CMD_N,
  output logic RES_VALID,
  input wire logic RES_READY,
  output logic RES_RUNG_OUT,
  input wire logic HOST_WE,
  input wire logic HOST_RE,
  input wire logic [AW-1:0] HOST_ADDR,
  input wire logic [`TMSA_WORD_W-1:0] HOST_WDATA,
  output logic HOST_READY,
  output logic HOST_RVALID,
  output logic [`TMSA_WORD_W-1:0] HOST_RDATA
);
  localparam int DW = `TMSA_WORD_W;
  localparam int NW = `TMSA_N_W;

  tmsa_mem_if #(.AW(AW), .DW(DW)) mport ();
  tmsa_mem #(.AW(AW), .DW(DW)) u_mem (.clk(MCLK), .port(mport));

  // Saturate a 17-bit signed result to 16 bits; flag tells whether it clipped
  function automatic logic [DW:0] sat16(input logic [DW:0] wide);
    if (wide[DW] == wide[DW-1]) begin
      sat16 = {1'b0, wide[DW-1:0]};
    end else if (wide[DW]) begin
      sat16 = {1'b1, `TMSA_SAT_MIN};
    end else begin
      sat16 = {1'b1, `TMSA_SAT_MAX};
    end
  endfunction

  tmsa_state_t state;
  tmsa_state_t next_state;
  tmsa_op_t op;
  logic [AW-1:0] a_base;
  logic [AW-1:0] b_base;
  logic [AW-1:0] c_base;
  logic [NW-1:0] count;
  logic [NW-1:0] idx;
  logic descend;
  logic [DW-1:0] op_a;
  logic rung;
  logic [1:0] buf_cnt;
  logic [1:0] buf_out;
  logic buf_full;
  logic push;
  logic last;
  logic [AW-1:0] offset;
  logic [DW:0] sum_wide;
  logic [DW:0] sat_res;

  // ==================================================
  // Command acceptance
  assign CMD_READY = (state == TMSA_ST_IDLE);
  assign HOST_READY = (state == TMSA_ST_IDLE) && !CMD_VALID;
  assign last = (idx == count - NW'(1));
  // Descending walk keeps overlapping copies intact
  assign offset = descend ? AW'(count - NW'(1) - idx) : AW'(idx);

  // Sign-extended arithmetic on 16-bit words
  always_comb begin
    if (op == TMSA_OP_SUB) begin
      sum_wide = {op_a[DW-1], op_a} - {mport.rdata[DW-1], mport.rdata};
    end else begin
      sum_wide = {op_a[DW-1], op_a} + {mport.rdata[DW-1], mport.rdata};
    end
    sat_res = sat16(sum_wide);
  end

  // ==================================================
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      TMSA_ST_IDLE: begin
        if (CMD_VALID) begin
          if (!CMD_RUNG_IN) begin
            next_state = TMSA_ST_DONE;
          end else if ((CMD_OP inside {3'h1, 3'h2, 3'h3})
                       && (CMD_N < `TMSA_N_MIN || CMD_N > `TMSA_N_MAX)) begin
            next_state = TMSA_ST_DONE;
          end else if (CMD_OP > 3'h5) begin
            next_state = TMSA_ST_DONE;
          end else begin
            next_state = TMSA_ST_RD_A;
          end
        end
      end
      TMSA_ST_RD_A: next_state = TMSA_ST_RD_B;
      TMSA_ST_RD_B: begin
        if (op == TMSA_OP_COPY || op == TMSA_OP_INV) begin
          next_state = last ? TMSA_ST_DONE : TMSA_ST_RD_A;
        end else begin
          next_state = TMSA_ST_WR_1;
        end
      end
      TMSA_ST_WR_1: begin
        if (op == TMSA_OP_FILL) begin
          next_state = last ? TMSA_ST_DONE : TMSA_ST_WR_1;
        end else if (op == TMSA_OP_SWAP) begin
          next_state = TMSA_ST_WR_2;
        end else begin
          next_state = TMSA_ST_DONE;
        end
      end
      TMSA_ST_WR_2: next_state = TMSA_ST_DONE;
      TMSA_ST_DONE: next_state = buf_full ? TMSA_ST_DONE : TMSA_ST_IDLE;
      default: next_state = TMSA_ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= TMSA_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==================================================
  // Latched command and walk index
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op <= TMSA_OP_SWAP;
      a_base <= '0;
      b_base <= '0;
      c_base <= '0;
      count <= '0;
      descend <= 1'b0;
    end else if (state == TMSA_ST_IDLE && CMD_VALID) begin
      op <= tmsa_op_t'(CMD_OP);
      a_base <= CMD_A;
      b_base <= CMD_B;
      c_base <= CMD_C;
      count <= CMD_N;
      descend <= (CMD_B > CMD_A);
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      idx <= '0;
    end else if (state == TMSA_ST_IDLE) begin
      idx <= '0;
    end else if ((state == TMSA_ST_RD_B && (op == TMSA_OP_COPY || op == TMSA_OP_INV))
                 || (state == TMSA_ST_WR_1 && op == TMSA_OP_FILL)) begin
      idx <= idx + NW'(1);
    end
  end

  // First operand captured as it leaves the register file
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op_a <= '0;
    end else if (state == TMSA_ST_RD_B) begin
      op_a <= mport.rdata;
    end
  end

  // ==================================================
  // Register file port steering; host gets it only while idle
  always_comb begin
    mport.we = 1'b0;
    mport.waddr = HOST_ADDR;
    mport.wdata = HOST_WDATA;
    mport.raddr = HOST_ADDR;
    unique case (state)
      TMSA_ST_IDLE: begin
        mport.we = HOST_WE && HOST_READY;
        if (CMD_VALID) begin
          mport.raddr = CMD_A;
        end
      end
      TMSA_ST_RD_A: begin
        mport.raddr = (op == TMSA_OP_COPY || op == TMSA_OP_INV) ? a_base + offset : a_base;
      end
      TMSA_ST_RD_B: begin
        mport.raddr = b_base;
        if (op == TMSA_OP_COPY) begin
          mport.we = 1'b1;
          mport.waddr = b_base + offset;
          mport.wdata = mport.rdata;
        end else if (op == TMSA_OP_INV) begin
          mport.we = 1'b1;
          mport.waddr = b_base + offset;
          mport.wdata = ~mport.rdata;
        end
      end
      TMSA_ST_WR_1: begin
        mport.we = 1'b1;
        if (op == TMSA_OP_FILL) begin
          mport.waddr = b_base + AW'(idx);
          mport.wdata = op_a;
        end else if (op == TMSA_OP_SWAP) begin
          mport.waddr = a_base;
          mport.wdata = mport.rdata;
        end else begin
          mport.waddr = c_base;
          mport.wdata = sat_res[DW-1:0];
        end
      end
      TMSA_ST_WR_2: begin
        mport.we = 1'b1;
        mport.waddr = b_base;
        mport.wdata = op_a;
      end
      TMSA_ST_DONE: begin
        mport.we = 1'b0;
      end
      default: mport.we = 1'b0;
    endcase
  end

  // Host read data follows the registered read one cycle later
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_RVALID <= 1'b0;
      HOST_RDATA <= '0;
    end else begin
      HOST_RVALID <= HOST_RE && HOST_READY;
      HOST_RDATA <= mport.rdata;
    end
  end

  // ==================================================
  // Rung output of the running operation
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rung <= 1'b0;
    end else if (state == TMSA_ST_IDLE && CMD_VALID) begin
      // Table ops and swap report ON once executed; invalid or OFF input stays OFF
      rung <= CMD_RUNG_IN && (next_state == TMSA_ST_RD_A)
              && (CMD_OP != 3'h4) && (CMD_OP != 3'h5);
    end else if (state == TMSA_ST_WR_1 && (op == TMSA_OP_ADD || op == TMSA_OP_SUB)) begin
      rung <= sat_res[DW];
    end
  end

  // ==================================================
  // Two-entry result buffer; once a stalled receiver leaves both entries full, the datapath holds in DONE
  assign buf_full = (buf_cnt == 2'h2);
  assign push = (state == TMSA_ST_DONE) && !buf_full;
  assign RES_VALID = (buf_cnt != 2'h0);
  assign RES_RUNG_OUT = buf_out[0];

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      buf_cnt <= 2'h0;
      buf_out <= 2'h0;
    end else begin
      if (RES_VALID && RES_READY) begin
        buf_out <= {1'b0, buf_out[1]};
        if (push) begin
          buf_out[buf_cnt == 2'h1 ? 0 : 1] <= rung;
        end
      end else if (push) begin
        buf_out[buf_cnt[0]] <= rung;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, RES_VALID && RES_READY};
    end
  end
endmodule // tmsa_core
`default_nettype wire

// >>> rtl/tmsa_mem.sv
// Word register file with registered read data
`timescale 1ns/1ps
`default_nettype none
module tmsa_mem #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  input wire logic clk,
  tmsa_mem_if.mem port
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  // ==================================================
  // Write port; read returns the old word on a collision
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end
  always_ff @(posedge clk) begin
    port.rdata <= store[port.raddr];
  end
endmodule // tmsa_mem
`default_nettype wire

// >>> rtl/tmsa_mem_if.sv
// Interface carrying the register file ports
`timescale 1ns/1ps
`default_nettype none
interface tmsa_mem_if #(parameter int AW = 12, parameter int DW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> rtl/tmsa_pkg.sv
// Types shared by the datapath modules
package tmsa_pkg;
  // Operation codes offered by the sequencer
  typedef enum logic [2:0] {
    TMSA_OP_SWAP = 3'h0,
    TMSA_OP_FILL = 3'h1,
    TMSA_OP_COPY = 3'h2,
    TMSA_OP_INV = 3'h3,
    TMSA_OP_ADD = 3'h4,
    TMSA_OP_SUB = 3'h5
  } tmsa_op_t;
  // Sequencer states, Gray from TMSA_ST_IDLE through TMSA_ST_WR_2 to TMSA_ST_DONE; the return to idle flips all three bits
  typedef enum logic [2:0] {
    TMSA_ST_IDLE = 3'h0,
    TMSA_ST_RD_A = 3'h1,
    TMSA_ST_RD_B = 3'h3,
    TMSA_ST_WR_1 = 3'h2,
    TMSA_ST_WR_2 = 3'h6,
    TMSA_ST_DONE = 3'h7
  } tmsa_state_t;
endpackage
